// file: asr_host.sv
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = `ASR_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module asr_host
   import asr_pkg::*;
#(
   parameter int HALF_DIV = `ASR_HALF_DIV
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Link to the converter
   asr_link_if.host         link,
   // User side
   input  wire logic        run,
   input  wire logic        chain_level,
   output asr_word_t        res_data,
   output logic             res_valid,
   input  wire logic        res_ready,
   output logic             frame_error
);
   localparam int DW = $clog2(HALF_DIV + 1);

   logic [DW-1:0]         div_r;
   logic                  sclk_r;
   logic                  tick;
   logic                  rise_tick;
   logic                  fall_tick;
   logic [1:0]            busy_sy_r;
   logic [1:0]            mark_sy_r;
   logic [1:0]            data_sy_r;
   asr_host_e             st_r;
   logic [`ASR_CNT_W-1:0] rise_r;
   asr_word_t             word_r;
   logic                  cs_n_r;
   logic                  sel_n_r;
   logic                  push_r;
   logic                  err_r;
   logic                  fifo_ready;

   // The shift clock runs free from a divider of the local clock.
   assign tick      = (div_r == DW'(HALF_DIV - 1));
   assign rise_tick = tick && !sclk_r;
   assign fall_tick = tick && sclk_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_r  <= '0;
         sclk_r <= 1'b0;
      end else begin
         div_r <= tick ? '0 : div_r + 1'b1;
         if (tick) begin
            sclk_r <= !sclk_r;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_sy_r <= 2'h3;
         mark_sy_r <= 2'h0;
         data_sy_r <= 2'h0;
      end else begin
         busy_sy_r <= {busy_sy_r[0], link.busy_n};
         mark_sy_r <= {mark_sy_r[0], link.frame_marker};
         data_sy_r <= {data_sy_r[0], link.data_out};
      end
   end

   // Data are taken on the rise after each bit, which leaves the most
   // margin for the synchronisers on both ends.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r    <= HS_IDLE;
         rise_r  <= '0;
         cs_n_r  <= 1'b1;
         sel_n_r <= 1'b1;
         push_r  <= 1'b0;
         err_r   <= 1'b0;
         word_r  <= '0;
      end else begin
         push_r <= 1'b0;
         unique case (st_r)
            HS_IDLE: begin
               if (run && fifo_ready && busy_sy_r[1] && sclk_r && !tick) begin
                  st_r    <= HS_START;
                  cs_n_r  <= 1'b0;
                  sel_n_r <= 1'b0;
                  rise_r  <= '0;
               end
            end
            HS_START: begin
               if (fall_tick) begin
                  st_r <= HS_RELEASE;
               end
            end
            HS_RELEASE: begin
               // One cycle after pulse zero; the next rise is still
               // at least the release time away.
               cs_n_r <= 1'b1;
               st_r   <= HS_READ;
            end
            HS_READ: begin
               if (rise_tick) begin
                  rise_r <= rise_r + 1'b1;
                  if (rise_r + 1'b1 == `ASR_MSB_PULSE && !mark_sy_r[1]) begin
                     err_r <= 1'b1;
                  end
                  if (rise_r + 1'b1 > `ASR_MSB_PULSE) begin
                     word_r <= {word_r[`ASR_BITS-2:0], data_sy_r[1]};
                  end
                  if (rise_r + 1'b1 == `ASR_TAG_PULSE) begin
                     st_r <= HS_PUSH;
                  end
               end
            end
            HS_PUSH: begin
               sel_n_r <= 1'b1;
               push_r  <= 1'b1;
               st_r    <= HS_WAIT;
            end
            HS_WAIT: begin
               if (busy_sy_r[1]) begin
                  st_r <= HS_IDLE;
               end
            end
            default: begin
               st_r <= HS_IDLE;
            end
         endcase
      end
   end

   asr_fifo #(
      .WIDTH (`ASR_BITS),
      .DEPTH (`ASR_FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (push_r),
      .in_ready  (fifo_ready),
      .in_data   (word_r),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res_data)
   );

   assign link.conv_start_n        = cs_n_r;
   assign link.sel_n               = sel_n_r;
   assign link.read_shift_clock    = sclk_r;
   assign link.chain_in            = chain_level;
   assign link.clock_source_select = 1'b1;
   assign frame_error              = err_r;
endmodule

// file: asr_defs.svh
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// Word and frame layout, counted in rising edges of the shift clock.
`define ASR_BITS        16
`define ASR_CNT_W       5
`define ASR_MARK_PULSE  5'h01
`define ASR_MSB_PULSE   5'h02
`define ASR_LSB_PULSE   5'h11
`define ASR_TAG_PULSE   5'h12
`define ASR_RESULT_RST  16'h0000

// Times in ns, with their cycle counts at the local clock rate.
`define ASR_MCLK_NS     100
`define ASR_BUSY_MAX_NS 83
`define ASR_REL_MIN_NS  15
`define ASR_CYC_FLOOR(ns) ((((ns) / `ASR_MCLK_NS) < 1) ? 1 : ((ns) / `ASR_MCLK_NS))
`define ASR_CYC_CEIL(ns)  ((((ns) + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS < 1) ? 1 : \
                           (((ns) + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS))
`define ASR_BUSY_MAX_CYC `ASR_CYC_FLOOR(`ASR_BUSY_MAX_NS)
`define ASR_REL_MIN_CYC  `ASR_CYC_CEIL(`ASR_REL_MIN_NS)

// Defaults for the counts that a bench may shorten.
`define ASR_CONV_CYC    400
`define ASR_HALF_DIV    4
`define ASR_FIFO_DEPTH  32

`endif

// file: asr_pkg.sv
package asr_pkg;
   typedef enum logic [0:0] {
      CV_IDLE = 1'b0,
      CV_BUSY = 1'b1
   } asr_conv_e;

   typedef enum logic [2:0] {
      HS_IDLE    = 3'b000,
      HS_START   = 3'b001,
      HS_RELEASE = 3'b010,
      HS_READ    = 3'b011,
      HS_PUSH    = 3'b100,
      HS_WAIT    = 3'b101
   } asr_host_e;

   typedef logic [15:0] asr_word_t;
endpackage

// file: asr_link_if.sv
`timescale 1ns/1ps
interface asr_link_if;
   // Driven by the host.
   logic conv_start_n;
   logic sel_n;
   logic read_shift_clock;
   logic chain_in;
   logic clock_source_select;
   // Driven by the converter.
   logic busy_n;
   logic frame_marker;
   logic data_out;

   modport dev (
      input  conv_start_n,
      input  sel_n,
      input  read_shift_clock,
      input  chain_in,
      input  clock_source_select,
      output busy_n,
      output frame_marker,
      output data_out
   );

   modport host (
      output conv_start_n,
      output sel_n,
      output read_shift_clock,
      output chain_in,
      output clock_source_select,
      input  busy_n,
      input  frame_marker,
      input  data_out
   );
endinterface

// file: asr_device.sv
// Function
// - Arm marker on clock edge: select high, or both low
// - Host toggles select; never holds it low
// - Host starts conversion: start and select low
// - Busy output falls promptly after start falls
// - Host releases start before requesting pulse one
// - Marker driven after pulse one rising edge
// - Most significant bit driven after pulse two
// - Least significant bit held through pulse eighteen
// - After pulse eighteen, output chain bit from two
// - Shifted word is the previous conversion result
// - Host finishes reading in first busy half
// - Host shift clock fast enough for that
// - Mode valid only with external clock selected
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_device
   import asr_pkg::*;
#(
   parameter int CONV_CYCLES = `ASR_CONV_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Link to the host
   asr_link_if.dev          link,
   // Converter core
   input  wire asr_word_t   sample_code,
   output logic             conv_done,
   output asr_word_t        conv_code
);

   localparam int CW = $clog2(CONV_CYCLES + 1);

   // Two-stage synchronisers for every link input.
   logic [1:0] clk_sy_r;
   logic [1:0] sel_sy_r;
   logic [1:0] cs_sy_r;
   logic [1:0] tag_sy_r;
   logic [1:0] ext_sy_r;
   logic       clk_d_r;
   logic       cs_d_r;

   logic       clk_s;
   logic       sel_s;
   logic       cs_s;
   logic       tag_s;
   logic       ext_s;
   logic       clk_edge;
   logic       clk_rise;
   logic       cs_fall;
   logic       read_on;

   asr_conv_e       conv_r;
   logic [CW-1:0]   conv_cnt_r;
   asr_word_t       held_r;
   asr_word_t       shift_r;
   logic            armed_r;
   logic [`ASR_CNT_W-1:0] pulse_r;
   logic            tag_r;
   logic            busy_n_r;
   logic            mark_r;
   logic            data_r;
   logic            done_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_sy_r <= 2'h0;
         sel_sy_r <= 2'h3;
         cs_sy_r  <= 2'h3;
         tag_sy_r <= 2'h0;
         ext_sy_r <= 2'h0;
      end else begin
         clk_sy_r <= {clk_sy_r[0], link.read_shift_clock};
         sel_sy_r <= {sel_sy_r[0], link.sel_n};
         cs_sy_r  <= {cs_sy_r[0], link.conv_start_n};
         tag_sy_r <= {tag_sy_r[0], link.chain_in};
         ext_sy_r <= {ext_sy_r[0], link.clock_source_select};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end else begin
         clk_d_r <= clk_s;
         cs_d_r  <= cs_s;
      end
   end

   assign clk_s    = clk_sy_r[1];
   assign sel_s    = sel_sy_r[1];
   assign cs_s     = cs_sy_r[1];
   assign tag_s    = tag_sy_r[1];
   assign ext_s    = ext_sy_r[1];
   assign clk_edge = ext_s && (clk_s != clk_d_r);
   assign clk_rise = clk_edge && clk_s;
   assign cs_fall  = ext_s && cs_d_r && !cs_s && !sel_s;
   assign read_on  = armed_r && !sel_s && cs_s;

   // Conversion timing; the busy output falls on the edge after the
   // synchronised start fall is seen.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conv_r     <= CV_IDLE;
         conv_cnt_r <= '0;
      end else begin
         unique case (conv_r)
            CV_IDLE: begin
               if (cs_fall) begin
                  conv_r     <= CV_BUSY;
                  conv_cnt_r <= CW'(CONV_CYCLES - 1);
               end
            end
            CV_BUSY: begin
               if (conv_cnt_r == '0) begin
                  conv_r <= CV_IDLE;
               end else begin
                  conv_cnt_r <= conv_cnt_r - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_n_r <= 1'b1;
      end else if (conv_r == CV_IDLE && cs_fall) begin
         busy_n_r <= 1'b0;
      end else if (conv_r == CV_BUSY && conv_cnt_r == '0) begin
         busy_n_r <= 1'b1;
      end
   end

   // The input is sampled at start; the code is ready when busy ends.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         held_r <= `ASR_RESULT_RST;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (conv_r == CV_IDLE && cs_fall) begin
            held_r <= sample_code;
         end
         if (conv_r == CV_BUSY && conv_cnt_r == '0) begin
            done_r <= 1'b1;
         end
      end
   end

   // The last finished code is kept as the word for the next read.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conv_code <= `ASR_RESULT_RST;
      end else if (conv_r == CV_BUSY && conv_cnt_r == '0) begin
         conv_code <= held_r;
      end
   end

   // Arming resets the pulse count; reading stops after the tag pulse.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         armed_r <= 1'b0;
         pulse_r <= '0;
      end else if (clk_edge && (sel_s || !cs_s)) begin
         armed_r <= 1'b1;
         pulse_r <= '0;
      end else if (read_on && clk_rise) begin
         pulse_r <= pulse_r + 1'b1;
         if (pulse_r + 1'b1 == `ASR_TAG_PULSE) begin
            armed_r <= 1'b0;
         end
      end
   end

   // The word loaded at start is the previous conversion's code.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shift_r <= `ASR_RESULT_RST;
      end else if (conv_r == CV_IDLE && cs_fall) begin
         shift_r <= conv_code;
      end else if (read_on && clk_rise && pulse_r + 1'b1 >= `ASR_MSB_PULSE &&
                   pulse_r + 1'b1 <= `ASR_LSB_PULSE) begin
         shift_r <= {shift_r[`ASR_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tag_r <= 1'b0;
      end else if (read_on && clk_rise && pulse_r + 1'b1 == `ASR_MSB_PULSE) begin
         tag_r <= tag_s;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mark_r <= 1'b0;
      end else if (read_on && clk_rise) begin
         mark_r <= (pulse_r + 1'b1 == `ASR_MARK_PULSE);
      end
   end

   // Each bit stands from its rise to the next, so it is valid at the
   // fall of its own pulse and the rise of the following one.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         data_r <= 1'b0;
      end else if (read_on && clk_rise) begin
         if (pulse_r + 1'b1 == `ASR_TAG_PULSE) begin
            data_r <= tag_r;
         end else if (pulse_r + 1'b1 >= `ASR_MSB_PULSE) begin
            data_r <= shift_r[`ASR_BITS-1];
         end
      end
   end

   assign link.busy_n       = busy_n_r;
   assign link.frame_marker = mark_r;
   assign link.data_out     = data_r;
   assign conv_done         = done_r;

endmodule

// file: asr_link_properties.sv
`timescale 1ns/1ps
module asr_link_properties #(
   parameter int CONV_CYCLES = 400,
   parameter int HALF_DIV    = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Host to converter
   input wire logic conv_start_n,
   input wire logic sel_n,
   input wire logic read_shift_clock,
   input wire logic chain_in,
   input wire logic clock_source_select,
   // Converter to host
   input wire logic busy_n,
   input wire logic frame_marker,
   input wire logic data_out
);
   logic       sck_r;
   logic       armed_r;
   logic       tag_r;
   logic [4:0] pulse_r;
   logic [2:0] age_r;
   logic [9:0] busy_cnt_r;
   logic [9:0] sel_low_r;
   logic       arm;
   logic       counted;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // Mirrors the read frame: an edge in the arming state clears the pulse count.
   assign arm     = (read_shift_clock ^ sck_r) & (sel_n | ~conv_start_n);
   assign counted = read_shift_clock & ~sck_r & armed_r & ~sel_n & conv_start_n;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sck_r      <= 1'b0;
         armed_r    <= 1'b0;
         pulse_r    <= 5'h00;
         tag_r      <= 1'b0;
         age_r      <= 3'h7;
         busy_cnt_r <= 10'h000;
         sel_low_r  <= 10'h000;
      end else begin
         sck_r      <= read_shift_clock;
         age_r      <= counted ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
         busy_cnt_r <= busy_n ? 10'h000 : busy_cnt_r + 10'h001;
         sel_low_r  <= sel_n ? 10'h000 : sel_low_r + 10'h001;
         if (arm) begin
            armed_r <= 1'b1;
            pulse_r <= 5'h00;
         end else if (counted && pulse_r != 5'h12) begin
            pulse_r <= pulse_r + 5'h01;
         end
         if (counted && pulse_r == 5'h01) begin
            tag_r <= chain_in;
         end
      end
   end

   chk_busy_prompt: assert property ($fell(conv_start_n) && busy_n && !sel_n |-> ##[1:4] !busy_n)
      else $error("busy late");
   chk_start_order: assert property ($fell(conv_start_n) |-> !sel_n && busy_n)
      else $error("bad start");
   chk_release_gap: assert property (counted && pulse_r == 5'h00 |-> $past(conv_start_n))
      else $error("start not released");
   chk_marker_on: assert property (counted && pulse_r == 5'h00 |-> ##[1:5] frame_marker)
      else $error("marker missing");
   chk_marker_off: assert property (counted && pulse_r == 5'h01 |-> ##[1:5] !frame_marker)
      else $error("marker too long");
   chk_data_timing: assert property ($changed(data_out) |-> pulse_r >= 5'h02 && age_r <= 3'h4)
      else $error("data moved off frame");
   chk_tag_out: assert property (counted && pulse_r == 5'h11 |-> ##5 (data_out == tag_r) [*3])
      else $error("tag level wrong");
   chk_half_busy: assert property (busy_cnt_r == 10'(CONV_CYCLES / 2) |-> sel_n)
      else $error("read past half");
   chk_ext_source: assert property (!sel_n |-> clock_source_select)
      else $error("internal source");
   // Select must come back high within 20 periods of the shift clock.
   chk_sel_release: assert property (sel_low_r < 10'(2 * 20 * HALF_DIV))
      else $error("select held low");

   cover property (counted && pulse_r == 5'h11);
   cover property ($fell(busy_n));
   cover property ($rose(frame_marker) ##[1:20] $changed(data_out));
endmodule

// file: test_adc_serial_readout_during_conversion.sv
`timescale 1ns/1ps
module test_adc_serial_readout_during_conversion;
   import asr_pkg::*;
   localparam int CONV = 400;
   logic      mclk;
   logic      resetn;
   logic      run;
   logic      chain_level;
   logic      res_ready;
   logic      res_valid;
   logic      frame_error;
   logic      conv_done;
   asr_word_t sample_code;
   asr_word_t res_data;
   asr_word_t conv_code;
   int        n_errors = 0;
   int        compares = 0;
   int        n_done = 0;
   int        n_pops = 0;
   int        mark;

   asr_link_if link ();

   asr_device #(.CONV_CYCLES(CONV)) asr_device_inst (
      .mclk(mclk), .resetn(resetn), .link(link.dev),
      .sample_code(sample_code), .conv_done(conv_done), .conv_code(conv_code));
   asr_host #(.HALF_DIV(4)) asr_host_inst (
      .mclk(mclk), .resetn(resetn), .link(link.host), .run(run), .chain_level(chain_level),
      .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready), .frame_error(frame_error));
   asr_link_properties #(.CONV_CYCLES(CONV), .HALF_DIV(4)) asr_link_properties_inst (
      .mclk(mclk), .resetn(resetn), .conv_start_n(link.conv_start_n), .sel_n(link.sel_n),
      .read_shift_clock(link.read_shift_clock), .chain_in(link.chain_in),
      .clock_source_select(link.clock_source_select), .busy_n(link.busy_n),
      .frame_marker(link.frame_marker), .data_out(link.data_out));

   always #50 mclk = ~mclk;

   function automatic asr_word_t code_of(input int k);
      return (k == 1) ? 16'hffff : (k == 2) ? 16'h0000 : asr_word_t'(k * 32'h3b59) ^ 16'h8001;
   endfunction

   task automatic check_word(input asr_word_t got, input asr_word_t exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Each finished conversion is checked, then the next sample and chain level are set up.
   always @(negedge mclk) begin
      if (conv_done === 1'b1) begin
         check_word(conv_code, code_of(n_done));
         n_done++;
         sample_code = code_of(n_done);
         chain_level = n_done[0];
      end
   end

   always @(posedge mclk) begin
      if (res_valid === 1'b1 && res_ready === 1'b1) begin
         check_word(res_data, (n_pops == 0) ? 16'h0000 : code_of(n_pops - 1));
         n_pops++;
      end
   end

   task automatic wait_pops(input int target);
      int i;
      i = 0;
      while (n_pops < target && i < 20000) begin
         @(negedge mclk);
         i++;
      end
      check_bit(n_pops >= target, 1'b1);
   endtask

   task automatic t_idle();
      check_bit(link.busy_n, 1'b1);
      check_bit(link.frame_marker, 1'b0);
      check_bit(link.sel_n, 1'b1);
      check_bit(link.conv_start_n, 1'b1);
      check_bit(res_valid, 1'b0);
      check_word(conv_code, 16'h0000);
      check_bit(link.clock_source_select, 1'b1);
   endtask

   task automatic t_stream(input int n);
      @(negedge mclk);
      run = 1'b1;
      res_ready = 1'b1;
      wait_pops(n_pops + n);
   endtask

   // Stalls the reader until conversions stop, then drains the buffer in one burst.
   task automatic t_fill();
      int i;
      @(negedge mclk);
      res_ready = 1'b0;
      i = 0;
      do begin
         mark = n_done;
         repeat (3 * CONV) @(negedge mclk);
         i++;
      end while (n_done != mark && i < 20);
      check_bit(n_done == mark, 1'b1);
      check_bit(res_valid, 1'b1);
      mark = n_pops;
      res_ready = 1'b1;
      i = 0;
      while (res_valid === 1'b1 && i < 100) begin
         @(negedge mclk);
         i++;
      end
      check_bit(n_pops - mark >= 32 && n_pops - mark <= 33, 1'b1);
   endtask

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      run = 1'b0;
      chain_level = 1'b0;
      res_ready = 1'b0;
      sample_code = code_of(0);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      resetn = 1'b1;
      t_idle();
      t_stream(6);
      t_fill();
      t_stream(2);
      check_bit(frame_error, 1'b0);
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      give_verdict();
   end
endmodule
